// ==== dv/tb_top.sv ====
// Purpose: self-checking bench of the subslot switch control
// Assumes: frame strobe made by the bench
// Notes: lookups checked through an expectation queue
`timescale 1ns/1ns
`include "tss_consts.svh"
module tb_top;
    import tss_pkg::*;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, frame, host_to, er;
    logic [7:0] paddr, tx_oe, sel, sv, slot, p, pp, oe;
    logic [31:0] pwdata, prdata, q;
    logic [6:0] tx_slot;
    logic [3:0] c, pc, nib;
    tss_sw_req_t req;
    tss_sw_rsp_t rsp, e;
    tss_sw_rsp_t exp_q[$];
    integer seed;
    int num_errors = 0;
    int n_tests = 0;
    tss_switch_ctrl uut (.CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .FRAME_I(frame), .SW_REQ_I(req),
        .SW_RSP_O(rsp), .TX_SLOT_I(tx_slot), .TX_OE_O(tx_oe));
    tss_host host (.clk_i(clk), .pready_i(pready), .pslverr_i(pslverr), .prdata_i(prdata),
        .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
        .pwdata_o(pwdata), .to_o(host_to));
    // ****************************************
    // helpers
    // ****************************************
    task automatic fail(input string m);
        num_errors++;
        $display("[FAIL] %0t %s", $time, m);
    endtask : fail
    task automatic report_and_stop;
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic xe);
        host.xfer(1'b0, a, 8'h00, q, er);
        n_tests++;
        if ({er, q} !== {xe, 24'h000000, x})
            fail("register read");
    endtask : rd
    task automatic pulse;
        frame <= 1'b1;
        @(posedge clk);
        frame <= 1'b0;
        @(posedge clk);
    endtask : pulse
    function automatic tss_sw_rsp_t expect_rsp(input logic [3:0] cc, input logic [1:0] s,
        input logic [7:0] pt, input logic [7:0] ci, input logic [7:0] pi);
        tss_sw_rsp_t r;
        logic [7:0] w;
        int pl;
        int cl;
        r = '0;
        w = 8'h00;
        pl = 0;
        cl = 0;
        if (cc == `TSS_CODE_FULL)
            w = 8'hff;
        else if (cc[3:1] == 3'b001)
        begin
            w = 8'h0f;
            pl = cc[0] ? 4 : 0;
            cl = s[0] ? 0 : 4;
        end
        else if (cc[3:2] == 2'b01)
        begin
            w = 8'h03;
            pl = 2 * int'(cc[1:0]);
            cl = 6 - 2 * int'(s);
        end
        r.valid = 1'b1;
        r.up = pt[7];
        r.code = cc;
        r.ptr = pt;
        r.pcm_mask = 8'(w << pl);
        r.cfi_mask = 8'(w << cl);
        r.pcm_data = 8'(((ci >> cl) & w) << pl);
        r.cfi_data = 8'(((pi >> pl) & w) << cl);
        return r;
    endfunction : expect_rsp
    task automatic look(input logic [3:0] cc, input logic [7:0] pt);
        logic [7:0] ci;
        logic [7:0] pi;
        ci = 8'($random(seed));
        pi = 8'($random(seed));
        req <= '{1'b1, slot, ci, pi};
        exp_q.push_back(expect_rsp(cc, sel[2*slot[1:0] +: 2], pt, ci, pi));
        @(posedge clk);
        req.valid <= 1'b0;
        @(posedge clk);
    endtask : look
    // ****************************************
    // clock, watchers and sequence
    // ****************************************
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk)
        if (host_to === 1'b1)
        begin
            fail("bus wait timeout");
            report_and_stop();
        end
    always @(posedge clk)
        if (rsp.valid === 1'b1)
        begin
            n_tests++;
            if (exp_q.size() == 0)
                fail("unexpected lookup answer");
            else
            begin
                e = exp_q.pop_front();
                if ({rsp.code, rsp.pcm_mask, rsp.cfi_mask, rsp.pcm_data, rsp.cfi_data} !==
                    {e.code, e.pcm_mask, e.cfi_mask, e.pcm_data, e.cfi_data} ||
                    (e.code != 4'h0 && {rsp.up, rsp.ptr} !== {e.up, e.ptr}))
                    fail("lookup answer");
            end
        end
    initial
    begin
        seed = 32'hec18f7ef;
        rstn = 1'b0;
        frame = 1'b0;
        req = '0;
        tx_slot = 7'h00;
        sel = 8'h00;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(`TSS_OFS_SEL, `TSS_SEL_RESET, 1'b0);
        rd(8'h20, 8'h00, 1'b1);
        for (int k = 0; k < 2; k++)
        begin
            sv = k ? 8'h1b : 8'he4;
            host.xfer(1'b1, `TSS_OFS_SEL, sv, q, er);
            rd(`TSS_OFS_SEL, sv, 1'b0);
            pulse();
            sel = sv;
            for (int port = 0; port < 4; port++)
            begin
                slot = {k[0], 5'(port + 4 * k), 2'(port)};
                pc = `TSS_CODE_UNASSIGNED;
                pp = 8'h00;
                for (int i = 1; i < 9; i++)
                begin
                    c = 4'(i % 8);
                    p = 8'($random(seed));
                    host.cmd(p, slot, {`TSS_MOC_SWITCH, c});
                    look(pc, pp);
                    pulse();
                    host.poll();
                    look(c, p);
                    host.cmd(8'h00, slot, `TSS_CMD_RD_CODE);
                    host.poll();
                    rd(`TSS_OFS_DATA, {4'h0, c}, 1'b0);
                    if (c != 4'h0)
                    begin
                        host.cmd(8'h00, slot, `TSS_CMD_RD_DATA);
                        host.poll();
                        rd(`TSS_OFS_DATA, p, 1'b0);
                        p = ~p;
                        host.cmd(p, slot, `TSS_CMD_DATA_ONLY);
                        pulse();
                        host.poll();
                        look(c, p);
                        host.cmd(8'h00, slot, 8'h00);
                        host.poll();
                        look(c, p);
                    end
                    pc = c;
                    pp = p;
                end
            end
        end
        for (int i = 0; i < 4; i++)
        begin
            nib = (i == 0) ? 4'hf : (i == 1) ? 4'h0 : (i == 2) ? 4'h5 : 4'($random(seed));
            if (i != 1)
                tx_slot <= 7'($random(seed));
            @(posedge clk);
            host.cmd({4'($random(seed)), nib}, {1'b0, tx_slot}, `TSS_CMD_TRISTATE);
            pulse();
            host.poll();
            for (int b = 0; b < 4; b++)
                oe[2*b +: 2] = {2{nib[b]}};
            n_tests++;
            if (tx_oe !== oe)
                fail("drive enable");
        end
        repeat (2) @(posedge clk);
        if (exp_q.size() != 0)
            fail("missing lookup answer");
        report_and_stop();
    end
endmodule : tb_top

// ==== dv/tss_host.sv ====
// Purpose: apb host model programming the switch control
// Assumes: slave answers within twenty cycles
// Notes: signals change right after a rising edge only
`timescale 1ns/1ns
`include "tss_consts.svh"
module tss_host (
    input wire logic clk_i,
    input wire logic pready_i,
    input wire logic pslverr_i,
    input wire logic [31:0] prdata_i,
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [7:0] paddr_o,
    output logic [31:0] pwdata_o,
    output logic to_o
);
    // ****************************************
    // bus transfers
    // ****************************************
    initial
    begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 8'h00;
        pwdata_o = 32'h00000000;
        to_o = 1'b0;
    end
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [31:0] q, output logic err);
        int n = 0;
        psel_o <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o <= wr;
        paddr_o <= a;
        pwdata_o <= {24'h000000, d};
        @(posedge clk_i);
        penable_o <= 1'b1;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (pready_i !== 1'b1 && n < 20);
        q = prdata_i;
        err = pslverr_i;
        if (pready_i !== 1'b1)
            to_o <= 1'b1;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        @(posedge clk_i);
    endtask : xfer
    task automatic cmd(input logic [7:0] d, input logic [7:0] a, input logic [7:0] c);
        logic [31:0] q;
        logic e;
        xfer(1'b1, `TSS_OFS_DATA, d, q, e);
        xfer(1'b1, `TSS_OFS_ADDR, a, q, e);
        xfer(1'b1, `TSS_OFS_CMD, c, q, e);
    endtask : cmd
    task automatic poll;
        logic [31:0] q;
        logic e;
        int n = 0;
        do
        begin
            xfer(1'b0, `TSS_OFS_STATUS, 8'h00, q, e);
            n++;
        end
        while (q[`TSS_STAT_PEND_BIT] !== 1'b0 && n < 40);
        if (q[`TSS_STAT_PEND_BIT] !== 1'b0)
            to_o <= 1'b1;
    endtask : poll
endmodule : tss_host

// ==== logic/tss_consts.svh ====
// Purpose: constants of the subslot switch control block
// Assumes: 32-bit APB word per register
// Notes: offsets are byte addresses
`ifndef TSS_CONSTS_SVH
`define TSS_CONSTS_SVH
// ****************************************
// register offsets
// ****************************************
`define TSS_OFS_DATA 8'h00
`define TSS_OFS_ADDR 8'h04
`define TSS_OFS_CMD 8'h08
`define TSS_OFS_STATUS 8'h0c
`define TSS_OFS_SEL 8'h10
// ****************************************
// command codes and fields
// ****************************************
`define TSS_MOC_SWITCH 4'h7
`define TSS_CMD_DATA_ONLY 8'h48
`define TSS_CMD_TRISTATE 8'h60
`define TSS_CMD_RD_DATA 8'hc8
`define TSS_CMD_RD_CODE 8'hf0
`define TSS_STAT_PEND_BIT 0
`define TSS_DIR_BIT 7
// ****************************************
// reset values and codes
// ****************************************
`define TSS_SEL_RESET 8'h00
`define TSS_CODE_UNASSIGNED 4'h0
`define TSS_CODE_FULL 4'h1
`define TSS_TS_ALL_ON 4'hf
`define TSS_TS_ALL_OFF 4'h0
`endif

// ==== logic/tss_ctrl_mem.sv ====
// Purpose: switch control table and pcm tristate table
// Assumes: one write port, combinational read ports
// Notes: cleared by reset so every slot starts unassigned
`timescale 1ns/1ns
`include "tss_consts.svh"
module tss_ctrl_mem
#(
    parameter int CM_AW = 8,
    parameter int TS_AW = 7
)(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic cm_we_i,
    input wire logic cm_code_we_i,
    input wire logic [CM_AW-1:0] cm_waddr_i,
    input wire tss_pkg::tss_cm_entry_t cm_wdata_i,
    input wire logic [CM_AW-1:0] cm_raddr_a_i,
    output tss_pkg::tss_cm_entry_t cm_rdata_a_o,
    input wire logic [CM_AW-1:0] cm_raddr_b_i,
    output tss_pkg::tss_cm_entry_t cm_rdata_b_o,
    input wire logic ts_we_i,
    input wire logic [TS_AW-1:0] ts_waddr_i,
    input wire logic [3:0] ts_wdata_i,
    input wire logic [TS_AW-1:0] ts_raddr_i,
    output logic [3:0] ts_rdata_o
);
    import tss_pkg::*;
    tss_cm_entry_t switch_ctrl_table [2**CM_AW];
    logic [3:0] ts_table [2**TS_AW];
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            for (int i = 0; i < 2**CM_AW; i++)
                switch_ctrl_table[i] <= '0;
            for (int i = 0; i < 2**TS_AW; i++)
                ts_table[i] <= `TSS_TS_ALL_OFF;
        end
        else
        begin
            if (cm_we_i)
                switch_ctrl_table[cm_waddr_i].data <= cm_wdata_i.data;
            if (cm_we_i && cm_code_we_i)
                switch_ctrl_table[cm_waddr_i].code <= cm_wdata_i.code;
            if (ts_we_i)
                ts_table[ts_waddr_i] <= ts_wdata_i;
        end
    end
    assign cm_rdata_a_o = switch_ctrl_table[cm_raddr_a_i];
    assign cm_rdata_b_o = switch_ctrl_table[cm_raddr_b_i];
    assign ts_rdata_o = ts_table[ts_raddr_i];
endmodule : tss_ctrl_mem

// ==== logic/tss_pkg.sv ====
// Purpose: types of the subslot switch control block
// Assumes: nothing
// Notes: one-hot access states
package tss_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_READ = 3'b100
    } tss_state_t;
    typedef struct packed {
        logic [3:0] code;
        logic [7:0] data;
    } tss_cm_entry_t;
    typedef struct packed {
        logic valid;
        logic [7:0] slot;
        logic [7:0] cfi_data;
        logic [7:0] pcm_data;
    } tss_sw_req_t;
    typedef struct packed {
        logic valid;
        logic up;
        logic [3:0] code;
        logic [7:0] ptr;
        logic [7:0] pcm_mask;
        logic [7:0] cfi_mask;
        logic [7:0] pcm_data;
        logic [7:0] cfi_data;
    } tss_sw_rsp_t;
endpackage : tss_pkg

// ==== logic/tss_subslot_map.sv ====
// Purpose: bit masks and bit moves for one switched slot
// Assumes: code from control table, port selection active copy
// Notes: codes other than 0001..0111 switch nothing
`timescale 1ns/1ns
module tss_subslot_map (
    input wire logic [3:0] code_i,
    input wire logic [1:0] sel_i,
    input wire logic [7:0] cfi_i,
    input wire logic [7:0] pcm_i,
    output logic [7:0] pcm_mask_o,
    output logic [7:0] cfi_mask_o,
    output logic [7:0] pcm_o,
    output logic [7:0] cfi_o
);
    logic [7:0] wmask;
    logic [2:0] lp;
    logic [2:0] lc;
    always_comb
    begin
        wmask = 8'h00;
        lp = 3'h0;
        lc = 3'h0;
        case (code_i)
            4'h1: wmask = 8'hff;
            4'h3:
            begin
                wmask = 8'h0f;
                lp = 3'h4;
            end
            4'h2: wmask = 8'h0f;
            4'h7:
            begin
                wmask = 8'h03;
                lp = 3'h6;
            end
            4'h6:
            begin
                wmask = 8'h03;
                lp = 3'h4;
            end
            4'h5:
            begin
                wmask = 8'h03;
                lp = 3'h2;
            end
            4'h4: wmask = 8'h03;
            default: wmask = 8'h00;
        endcase
        if (wmask == 8'h0f)
            lc = sel_i[0] ? 3'h0 : 3'h4;
        else if (wmask == 8'h03)
        begin
            case (sel_i)
                2'b00: lc = 3'h6;
                2'b01: lc = 3'h4;
                2'b10: lc = 3'h2;
                default: lc = 3'h0;
            endcase
        end
        pcm_mask_o = wmask << lp;
        cfi_mask_o = wmask << lc;
        pcm_o = ((cfi_i >> lc) & wmask) << lp;
        cfi_o = ((pcm_i >> lp) & wmask) << lc;
    end
endmodule : tss_subslot_map

// ==== logic/tss_switch_ctrl.sv ====
// Purpose: control memory programming and subslot switching
// Assumes: APB master, frame strobe and lookups on CLK_I
// Notes: table and selection changes land on FRAME_I
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ns
`include "tss_consts.svh"
// Contract
// - code 0000 cancels a slot; data register ignored; slot stops switching.
// - tristate nibble 0000 keeps every bit of that pcm slot undriven.
// - command 60h reaches tristate field; nibble 1111 drives all bits.
// - each nibble bit drives one bit pair; 0101 drives 5..4 and 1..0.
// - code 0001 switches all eight bits whatever the port selection.
// - data register holds pcm pointer, address register selects cfi slot.
// - codes 0011/0010 switch pcm nibbles, 0111..0100 pcm bit pairs.
// - each of four ports has own two-bit subchannel selection.
// - bandwidth chosen per slot, positions fixed per port.
// - selection register 8 bits, RW, reset 00, port n at bits 2n+1:2n.
// - selection 00: nibble at cfi 7..4, pair at 7..6.
// - selection 01: nibble at cfi 3..0, pair at 5..4.
// - selection 10: nibble at cfi 7..4, pair at 3..2.
// - selection 11: nibble at cfi 3..0, pair at 1..0.
// - one subslot per cfi slot; pcm slot may hold several parts.
// - pointer msb set selects upstream pcm slot and data store.
module tss_switch_ctrl
(
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic FRAME_I,
    input wire tss_pkg::tss_sw_req_t SW_REQ_I,
    output tss_pkg::tss_sw_rsp_t SW_RSP_O,
    input wire logic [6:0] TX_SLOT_I,
    output logic [7:0] TX_OE_O
);
    import tss_pkg::*;
    // ****************************************
    // registers and state
    // ****************************************
    logic [7:0] mem_access_data, next_mem_access_data;
    logic [7:0] mem_access_addr, next_mem_access_addr;
    logic [7:0] mem_access_cmd, next_mem_access_cmd;
    logic [7:0] cfi_subslot_select, next_cfi_subslot_select;
    logic [7:0] sel_act, next_sel_act;
    logic mem_access_pending, next_mem_access_pending;
    tss_state_t state, next_state;
    logic [31:0] prdata, next_prdata;
    logic pready, next_pready;
    logic pslverr, next_pslverr;
    tss_sw_rsp_t rsp, next_rsp;
    logic [7:0] tx_oe, next_tx_oe;
    // ****************************************
    // bus decode
    // ****************************************
    logic setup, wr_acc, hit;
    logic cmd_wr, sel_wr;
    logic [3:0] access_mode_code;
    logic is_switch, is_data_only, is_ts, is_rd;
    assign setup = PSEL_I && !PENABLE_I;
    assign wr_acc = PSEL_I && PENABLE_I && pready && PWRITE_I && !pslverr;
    assign hit = (PADDR_I == `TSS_OFS_DATA) || (PADDR_I == `TSS_OFS_ADDR)
        || (PADDR_I == `TSS_OFS_CMD) || (PADDR_I == `TSS_OFS_STATUS)
        || (PADDR_I == `TSS_OFS_SEL);
    assign cmd_wr = wr_acc && (PADDR_I == `TSS_OFS_CMD);
    assign sel_wr = wr_acc && (PADDR_I == `TSS_OFS_SEL);
    assign access_mode_code = mem_access_cmd[7:4];
    assign is_switch = access_mode_code == `TSS_MOC_SWITCH;
    assign is_data_only = mem_access_cmd == `TSS_CMD_DATA_ONLY;
    assign is_ts = mem_access_cmd == `TSS_CMD_TRISTATE;
    assign is_rd = (mem_access_cmd == `TSS_CMD_RD_DATA)
        || (mem_access_cmd == `TSS_CMD_RD_CODE);
    // ****************************************
    // tables and slot mapping
    // ****************************************
    logic cm_we, ts_we, cm_code_we;
    tss_cm_entry_t cm_wdata, cm_host, cm_sw;
    logic [3:0] ts_nib;
    logic [7:0] pcm_mask, cfi_mask, pcm_out, cfi_out;
    logic [1:0] port_subslot_sel;
    logic [7:0] oe_exp;
    assign cm_we = (state == ST_WAIT) && FRAME_I && !is_ts;
    assign ts_we = (state == ST_WAIT) && FRAME_I && is_ts;
    assign cm_code_we = !is_data_only;
    assign cm_wdata.code = mem_access_cmd[3:0];
    assign cm_wdata.data = mem_access_data;
    tss_ctrl_mem #(
        .CM_AW(8),
        .TS_AW(7)
    ) u_mem (
        .clk_i(CLK_I),
        .rstn_i(RSTN_I),
        .cm_we_i(cm_we),
        .cm_code_we_i(cm_code_we),
        .cm_waddr_i(mem_access_addr),
        .cm_wdata_i(cm_wdata),
        .cm_raddr_a_i(mem_access_addr),
        .cm_rdata_a_o(cm_host),
        .cm_raddr_b_i(SW_REQ_I.slot),
        .cm_rdata_b_o(cm_sw),
        .ts_we_i(ts_we),
        .ts_waddr_i(mem_access_addr[6:0]),
        .ts_wdata_i(mem_access_data[3:0]),
        .ts_raddr_i(TX_SLOT_I),
        .ts_rdata_o(ts_nib)
    );
    // port number sits in the two low slot bits
    assign port_subslot_sel = sel_act[2*SW_REQ_I.slot[1:0] +: 2];
    tss_subslot_map u_map (
        .code_i(cm_sw.code),
        .sel_i(port_subslot_sel),
        .cfi_i(SW_REQ_I.cfi_data),
        .pcm_i(SW_REQ_I.pcm_data),
        .pcm_mask_o(pcm_mask),
        .cfi_mask_o(cfi_mask),
        .pcm_o(pcm_out),
        .cfi_o(cfi_out)
    );
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_oe
            assign oe_exp[2*g+1:2*g] = {2{ts_nib[g]}};
        end
    endgenerate
    // ****************************************
    // access sequencer
    // ****************************************
    always_comb
    begin
        next_state = state;
        next_mem_access_pending = mem_access_pending;
        next_mem_access_data = mem_access_data;
        next_mem_access_addr = mem_access_addr;
        next_mem_access_cmd = mem_access_cmd;
        next_cfi_subslot_select = cfi_subslot_select;
        next_sel_act = sel_act;
        if (wr_acc && PADDR_I == `TSS_OFS_DATA && !mem_access_pending)
            next_mem_access_data = PWDATA_I[7:0];
        if (wr_acc && PADDR_I == `TSS_OFS_ADDR && !mem_access_pending)
            next_mem_access_addr = PWDATA_I[7:0];
        if (sel_wr)
            next_cfi_subslot_select = PWDATA_I[7:0];
        if (FRAME_I)
            next_sel_act = cfi_subslot_select;
        case (state)
            ST_IDLE:
            begin
                if (cmd_wr)
                begin
                    next_mem_access_cmd = PWDATA_I[7:0];
                    next_mem_access_pending = 1'b1;
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                if (is_rd)
                    next_state = ST_READ;
                else if (!(is_switch || is_data_only || is_ts))
                begin
                    next_mem_access_pending = 1'b0;
                    next_state = ST_IDLE;
                end
                else if (FRAME_I)
                begin
                    next_mem_access_pending = 1'b0;
                    next_state = ST_IDLE;
                end
            end
            ST_READ:
            begin
                if (mem_access_cmd == `TSS_CMD_RD_CODE)
                    next_mem_access_data = {4'h0, cm_host.code};
                else
                    next_mem_access_data = cm_host.data;
                next_mem_access_pending = 1'b0;
                next_state = ST_IDLE;
            end
            default:
            begin
                next_state = ST_IDLE;
                next_mem_access_pending = 1'b0;
            end
        endcase
    end
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            state <= ST_IDLE;
            mem_access_pending <= 1'b0;
            mem_access_data <= 8'h00;
            mem_access_addr <= 8'h00;
            mem_access_cmd <= 8'h00;
            cfi_subslot_select <= `TSS_SEL_RESET;
            sel_act <= `TSS_SEL_RESET;
        end
        else
        begin
            state <= next_state;
            mem_access_pending <= next_mem_access_pending;
            mem_access_data <= next_mem_access_data;
            mem_access_addr <= next_mem_access_addr;
            mem_access_cmd <= next_mem_access_cmd;
            cfi_subslot_select <= next_cfi_subslot_select;
            sel_act <= next_sel_act;
        end
    end
    // ****************************************
    // apb answer
    // ****************************************
    always_comb
    begin
        next_pready = setup;
        next_pslverr = setup && !hit;
        next_prdata = 32'h0000_0000;
        if (setup && !PWRITE_I)
        begin
            case (PADDR_I)
                `TSS_OFS_DATA: next_prdata = {24'h0, mem_access_data};
                `TSS_OFS_ADDR: next_prdata = {24'h0, mem_access_addr};
                `TSS_OFS_CMD: next_prdata = {24'h0, mem_access_cmd};
                `TSS_OFS_STATUS: next_prdata = {31'h0, mem_access_pending};
                `TSS_OFS_SEL: next_prdata = {24'h0, cfi_subslot_select};
                default: next_prdata = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
        end
    end
    assign PREADY_O = pready;
    assign PSLVERR_O = pslverr;
    assign PRDATA_O = prdata;
    // ****************************************
    // switching lookup
    // ****************************************
    always_comb
    begin
        next_rsp = '0;
        next_rsp.valid = SW_REQ_I.valid;
        next_rsp.code = cm_sw.code;
        next_rsp.ptr = cm_sw.data;
        next_rsp.up = cm_sw.data[`TSS_DIR_BIT];
        next_rsp.pcm_mask = pcm_mask;
        next_rsp.cfi_mask = cfi_mask;
        next_rsp.pcm_data = pcm_out;
        next_rsp.cfi_data = cfi_out;
        next_tx_oe = oe_exp;
    end
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            rsp <= '0;
            tx_oe <= 8'h00;
        end
        else
        begin
            rsp <= next_rsp;
            tx_oe <= next_tx_oe;
        end
    end
    assign SW_RSP_O = rsp;
    assign TX_OE_O = tx_oe;
    // ****************************************
    // assertions
    // ****************************************
    logic [3:0] ts_nib_q;
    logic [1:0] sel_q;
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            ts_nib_q <= 4'h0;
            sel_q <= 2'b00;
        end
        else
        begin
            ts_nib_q <= ts_nib;
            sel_q <= port_subslot_sel;
        end
    end
    sequence s_cmd_taken;
        (state == ST_IDLE) && cmd_wr;
    endsequence
    sequence s_pend_set;
        mem_access_pending && (state == ST_WAIT);
    endsequence
    a_cmd_starts_access: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        s_cmd_taken |=> s_pend_set)
        else $error("command write did not start access");
    a_write_frame_only: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        (cm_we || ts_we) |-> FRAME_I && mem_access_pending)
        else $error("table written outside frame boundary");
    a_sel_at_frame: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        $changed(sel_act) |-> $past(FRAME_I))
        else $error("selection applied outside frame boundary");
    a_ts_all_off: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        ts_nib_q == `TSS_TS_ALL_OFF |-> tx_oe == 8'h00)
        else $error("driver enabled for disabled slot");
    a_ts_all_on: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        ts_nib_q == `TSS_TS_ALL_ON |-> tx_oe == 8'hff)
        else $error("driver not fully enabled");
    a_ts_pairs: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        ts_nib_q == 4'h5 |-> tx_oe == 8'h33)
        else $error("bit pair enables wrong");
    a_full_code: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        rsp.valid && rsp.code == `TSS_CODE_FULL
            |-> rsp.pcm_mask == 8'hff && rsp.cfi_mask == 8'hff)
        else $error("full code did not switch eight bits");
    a_cancel_idle: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        rsp.valid && rsp.code == `TSS_CODE_UNASSIGNED
            |-> rsp.pcm_mask == 8'h00 && rsp.cfi_mask == 8'h00)
        else $error("unassigned slot still switched");
    a_pair_sel00: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        rsp.valid && rsp.code == 4'h4 && sel_q == 2'b00
            |-> rsp.cfi_mask == 8'hc0 && rsp.pcm_mask == 8'h03)
        else $error("pair position wrong for selection 00");
    a_read_done: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        (state == ST_WAIT) && is_rd |=> ##1 !mem_access_pending)
        else $error("read access did not finish");
    a_reg_reset: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        $rose(RSTN_I) |-> cfi_subslot_select == `TSS_SEL_RESET)
        else $error("selection register not reset");
endmodule : tss_switch_ctrl
